/* design/wof_regs.svh */
// wof_regs.svh: constants for the waveform output formatter.
// assumes: included by bare name from the package, the formatter, the assertions and the testbench.
`ifndef WOF_REGS_SVH
`define WOF_REGS_SVH

`define WOF_HOLE_BYTE      8'h7d
`define WOF_HOLE_WORD      16'h7a00
`define WOF_HOLE_MARK      16'h8000
`define WOF_FMT_TEXT       2'h0
`define WOF_FMT_BINARY     2'h1
`define WOF_FMT_BYTE       2'h2
`define WOF_FMT_WORD       2'h3
`define WOF_FIFO_DEPTH     4
`define WOF_POINTS_W       24

`endif

/* design/wof_pkg.sv */
// wof_pkg.sv: types shared by the waveform output formatter.
// assumes: wof_regs.svh is on the include path.
`include "wof_regs.svh"

package wof_pkg;

    typedef enum logic [1:0]
    {
        WOF_SRC_ANALOG,
        WOF_SRC_POD_SINGLE,
        WOF_SRC_POD_ALL,
        WOF_SRC_HISTOGRAM
    } wof_src_e;

    typedef enum logic [1:0]
    {
        WOF_ST_IDLE,
        WOF_ST_FETCH,
        WOF_ST_SEND
    } wof_state_e;

endpackage : wof_pkg

/* design/wof_fifo.sv */
// wof_fifo.sv: small flip-flop FIFO with valid/ready on both sides.
// assumes: one clock, asynchronous active-low reset.
`timescale 1ns/10ps

module wof_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_sys,   // system clock
    input  wire logic             resetn,    // async reset, active low
    input  wire logic [WIDTH-1:0] in_data,   // write data
    input  wire logic             in_valid,  // write request
    output logic                  in_ready,  // space available
    output logic      [WIDTH-1:0] out_data,  // head entry
    output logic                  out_valid, // head entry present
    input  wire logic             out_ready  // reader takes head
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wptr;
        logic [AW-1:0]               rptr;
        logic [AW:0]                 count;
    } wof_fifo_s;

    wof_fifo_s st_reg;
    wof_fifo_s st_next;
    logic      push;
    logic      pop;

    assign in_ready  = (st_reg.count != DEPTH[AW:0]);
    assign out_valid = (st_reg.count != '0);
    assign out_data  = st_reg.mem[st_reg.rptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb
    begin
        st_next = st_reg;
        if (push)
        begin
            st_next.mem[st_reg.wptr] = in_data;
            st_next.wptr = (st_reg.wptr == AW'(DEPTH - 1)) ? '0 : st_reg.wptr + 1'b1;
        end
        if (pop)
        begin
            st_next.rptr = (st_reg.rptr == AW'(DEPTH - 1)) ? '0 : st_reg.rptr + 1'b1;
        end
        st_next.count = st_reg.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

endmodule : wof_fifo

/* design/wof_formatter.sv */
// wof_formatter.sv: turns stored 16-bit waveform samples into host bytes.
// assumes: a sample memory answers a read in the same cycle as the address,
// and the host link drains bytes with a valid/ready handshake.
// Function
// - byte mode sends signed 8-bit samples
// - byte mode hole code is 125
// - narrow 16-bit samples to 8 bits
// - all-pods source in byte mode errors
// - word mode sends 16-bit as two bytes
// - byte order chooses high or low first
// - word mode analog hole is 31232
// - digital channels never get hole codes
// - binary analog uses word encoding
// - binary single pod bytes, all-pods words
// - binary histogram sends 32-bit, no holes
// - histogram byte order follows setting
// - format query returns current mode
// - points query returns record length
// - text mode selected after reset
`timescale 1ns/10ps
`include "wof_regs.svh"

module wof_formatter #(
    parameter int POINTS_W = `WOF_POINTS_W,
    parameter int DEPTH    = `WOF_FIFO_DEPTH
) (
    input  wire logic                clk_sys,        // 20 MHz system clock
    input  wire logic                resetn,         // async reset, active low
    input  wire logic                fmt_write,      // pulse: load new format
    input  wire logic [1:0]          fmt_value,      // format code to load
    output logic      [1:0]          fmt_current,    // current format code
    input  wire logic                byte_order_setting, // 1: high_byte_first
    input  wire wof_pkg::wof_src_e   src_select,     // selected source
    input  wire logic [POINTS_W-1:0] src_points,     // buckets in selected record
    output logic      [POINTS_W-1:0] points_answer,  // points query reply
    input  wire logic                start,          // pulse: begin download
    output logic                     busy,           // download running
    output logic                     fmt_error,      // pulse: byte mode refused
    output logic      [POINTS_W-1:0] mem_addr,       // sample address
    output logic                     mem_rd,         // sample read strobe
    input  wire logic [31:0]         mem_data,       // sample, valid in the rd cycle
    input  wire logic                mem_hole,       // location unfilled
    output logic      [7:0]          out_byte,       // byte to host
    output logic                     out_valid,      // byte present
    input  wire logic                out_ready       // host takes byte
);
    typedef struct packed {
        wof_pkg::wof_state_e  state;
        logic [1:0]           fmt;
        logic [POINTS_W-1:0]  addr;
        logic [POINTS_W-1:0]  total;
        logic [31:0]          word;
        logic [1:0]           nbytes;
        logic [1:0]           idx;
        logic                 hi_first;
        logic                 err;
        logic [POINTS_W-1:0]  points;
    } wof_fmt_s;

    wof_fmt_s st_reg;
    wof_fmt_s st_next;
    logic [7:0]  fifo_din;
    logic        fifo_push;
    logic        fifo_ready;
    logic [1:0]  enc_bytes;
    logic [31:0] enc_word;
    logic [1:0]  sel;
    logic        hole_ok;
    logic [15:0] s16;

    wof_fifo #(
        .WIDTH (8),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .in_data   (fifo_din),
        .in_valid  (fifo_push),
        .in_ready  (fifo_ready),
        .out_data  (out_byte),
        .out_valid (out_valid),
        .out_ready (out_ready)
    );

    assign fmt_current   = st_reg.fmt;
    assign points_answer = st_reg.points;
    assign busy          = (st_reg.state != wof_pkg::WOF_ST_IDLE);
    assign fmt_error     = st_reg.err;
    assign mem_addr      = st_reg.addr;
    assign mem_rd        = (st_reg.state == wof_pkg::WOF_ST_FETCH);

    // width of one output word from format and source
    always_comb
    begin
        enc_bytes = 2'd1;
        case (st_reg.fmt)
            `WOF_FMT_BYTE:
                enc_bytes = 2'd0;
            `WOF_FMT_WORD:
                enc_bytes = 2'd1;
            `WOF_FMT_BINARY:
                case (src_select)
                    wof_pkg::WOF_SRC_HISTOGRAM:  enc_bytes = 2'd3;
                    wof_pkg::WOF_SRC_POD_SINGLE: enc_bytes = 2'd0;
                    default:                     enc_bytes = 2'd1;
                endcase
            default:
                enc_bytes = 2'd1;
        endcase
    end

    // holes only for analog data outside histogram
    assign hole_ok = mem_hole && (src_select == wof_pkg::WOF_SRC_ANALOG);
    assign s16     = mem_data[15:0];

    always_comb
    begin
        enc_word = mem_data;
        if (enc_bytes == 2'd0)
        begin
            // arithmetic shift keeps the sign; each 8-bit code covers 256 wide values
            enc_word = {24'h000000, s16[15:8]};
            if (hole_ok)
                enc_word = {24'h000000, `WOF_HOLE_BYTE};
            else if (src_select != wof_pkg::WOF_SRC_ANALOG)
                enc_word = {24'h000000, mem_data[7:0]};
        end
        else if (enc_bytes == 2'd1)
        begin
            enc_word = {16'h0000, s16};
            if (hole_ok)
                enc_word = {16'h0000, `WOF_HOLE_WORD};
        end
    end

    // byte lane picked by order; idx counts sent bytes
    assign sel      = st_reg.hi_first ? (st_reg.nbytes - st_reg.idx) : st_reg.idx;
    assign fifo_din = st_reg.word[8*sel +: 8];
    assign fifo_push = (st_reg.state == wof_pkg::WOF_ST_SEND);

    always_comb
    begin
        st_next = st_reg;
        st_next.err = 1'b0;
        st_next.points = src_points;
        if (fmt_write)
            st_next.fmt = fmt_value;
        case (st_reg.state)
            wof_pkg::WOF_ST_IDLE:
            begin
                if (start)
                begin
                    if ((st_reg.fmt == `WOF_FMT_BYTE) && (src_select == wof_pkg::WOF_SRC_POD_ALL))
                        st_next.err = 1'b1;
                    else if (src_points != '0)
                    begin
                        st_next.state    = wof_pkg::WOF_ST_FETCH;
                        st_next.addr     = '0;
                        st_next.total    = src_points;
                        st_next.hi_first = byte_order_setting;
                    end
                end
            end
            wof_pkg::WOF_ST_FETCH:
            begin
                st_next.state  = wof_pkg::WOF_ST_SEND;
                st_next.word   = enc_word;
                st_next.nbytes = enc_bytes;
                st_next.idx    = 2'd0;
            end
            wof_pkg::WOF_ST_SEND:
            begin
                // the fifo holds bytes while the host stalls; each fetch cycle still leaves a gap in the stream
                if (fifo_ready)
                begin
                    st_next.idx = st_reg.idx + 2'd1;
                    if (st_reg.idx == st_reg.nbytes)
                    begin
                        st_next.addr = st_reg.addr + 1'b1;
                        if (st_reg.addr == st_reg.total - 1'b1)
                            st_next.state = wof_pkg::WOF_ST_IDLE;
                        else
                            st_next.state = wof_pkg::WOF_ST_FETCH;
                    end
                end
            end
            default:
                st_next.state = wof_pkg::WOF_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            st_reg     <= '0;
            st_reg.fmt <= `WOF_FMT_TEXT;
        end
        else
            st_reg <= st_next;
    end

endmodule : wof_formatter

/* verification/wof_host_model.sv */
// wof_host_model.sv: sample memory and byte-reading host for the formatter.
// assumes: one clock; slow makes the host take a byte one cycle in four.
`timescale 1ns/10ps

module wof_host_model (
    input  wire logic        clk_sys,   // clock
    input  wire logic        resetn,    // reset
    input  wire logic        slow,      // host stalls
    input  wire logic [23:0] mem_addr,  // address
    input  wire logic        mem_rd,    // fetch
    output logic      [31:0] mem_data,  // sample
    output logic             mem_hole,  // hole
    input  wire logic [7:0]  out_byte,  // byte
    input  wire logic        out_valid, // valid
    output logic             out_ready  // ready
);
    logic [7:0] got[$];
    logic [1:0] tick;

    function automatic logic [31:0] sample(input logic [23:0] a);
        return {8'h40 | a[7:0], 8'h9c ^ a[7:0], 8'hc5 + a[7:0], 8'h1e + a[7:0]};
    endfunction : sample

    // inverse data outside the fetch cycle, so a late read cannot pass
    assign mem_data = mem_rd ? sample(mem_addr) : ~sample(mem_addr);
    assign mem_hole = mem_rd ? mem_addr == 24'h1 : 1'b1;

    always @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            tick <= 2'h0;
            out_ready <= 1'b0;
        end
        else
        begin
            tick <= tick + 2'h1;
            out_ready <= !slow || tick == 2'h3;
            if (out_valid && out_ready)
                got.push_back(out_byte);
        end
    end
endmodule : wof_host_model

/* verification/wof_formatter_asserts.sv */
// wof_formatter_asserts.sv: port timing checks for the formatter.
// assumes: bound to wof_formatter; one clock, reset active low.
`timescale 1ns/10ps
`include "wof_regs.svh"

module wof_formatter_asserts #(
    parameter int POINTS_W = `WOF_POINTS_W
) (
    input wire logic                clk_sys,            // clock
    input wire logic                resetn,             // reset
    input wire logic                fmt_write,          // load
    input wire logic [1:0]          fmt_value,          // code
    input wire logic [1:0]          fmt_current,        // format
    input wire logic                byte_order_setting, // order
    input wire wof_pkg::wof_src_e   src_select,         // source
    input wire logic [POINTS_W-1:0] src_points,         // length
    input wire logic [POINTS_W-1:0] points_answer,      // reply
    input wire logic                start,              // go
    input wire logic                busy,               // busy
    input wire logic                fmt_error,          // refused
    input wire logic [POINTS_W-1:0] mem_addr,           // address
    input wire logic                mem_rd,             // fetch
    input wire logic [31:0]         mem_data,           // sample
    input wire logic                mem_hole,           // hole
    input wire logic [7:0]          out_byte,           // byte
    input wire logic                out_valid,          // valid
    input wire logic                out_ready           // ready
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    property p_reset_text; !$past(resetn) |-> fmt_current == `WOF_FMT_TEXT; endproperty
    a_reset_text: assert property (p_reset_text) else $error("not text after reset");
    property p_fmt_load; fmt_write |=> fmt_current == $past(fmt_value); endproperty
    a_fmt_load: assert property (p_fmt_load) else $error("format not loaded");
    property p_fmt_hold; !fmt_write |=> $stable(fmt_current); endproperty
    a_fmt_hold: assert property (p_fmt_hold) else $error("format changed");
    property p_points; 1'b1 |=> points_answer == $past(src_points); endproperty
    a_points: assert property (p_points) else $error("points reply wrong");
    property p_refused; start && !busy && fmt_current == `WOF_FMT_BYTE
        && src_select == wof_pkg::WOF_SRC_POD_ALL |=> fmt_error && !busy; endproperty
    a_refused: assert property (p_refused) else $error("byte all-pods not refused");
    property p_err_cause; fmt_error |-> $past(start) && $past(src_select) == wof_pkg::WOF_SRC_POD_ALL; endproperty
    a_err_cause: assert property (p_err_cause) else $error("stray error pulse");
    property p_first_fetch; start && !busy && src_points != 0 && !(fmt_current == `WOF_FMT_BYTE
        && src_select == wof_pkg::WOF_SRC_POD_ALL) |=> busy && mem_rd && mem_addr == 0; endproperty
    a_first_fetch: assert property (p_first_fetch) else $error("first fetch wrong");
    property p_fetch_gap; mem_rd |=> !mem_rd; endproperty
    a_fetch_gap: assert property (p_fetch_gap) else $error("fetch too long");
    property p_addr_range; mem_rd |-> mem_addr < src_points; endproperty
    a_addr_range: assert property (p_addr_range) else $error("address past record");
    property p_hold; out_valid && !out_ready |=> out_valid && $stable(out_byte); endproperty
    a_hold: assert property (p_hold) else $error("byte dropped while stalled");
endmodule : wof_formatter_asserts

bind wof_formatter wof_formatter_asserts #(.POINTS_W(POINTS_W)) wof_formatter_asserts_inst (.*);

/* verification/testbench.sv */
// testbench.sv: runs format and source cases and compares host bytes.
// assumes: design files and wof_host_model are compiled first.
`timescale 1ns/10ps
`include "wof_regs.svh"

module testbench;
    logic              clk_sys = 0, resetn = 0, fmt_write = 0, byte_order_setting = 0, start = 0, slow = 0;
    logic [1:0]        fmt_value = 0, fmt_current;
    wof_pkg::wof_src_e src_select = wof_pkg::WOF_SRC_ANALOG;
    logic [23:0]       src_points = 0, points_answer, mem_addr;
    logic              busy, fmt_error, mem_rd, mem_hole, out_valid, out_ready;
    logic [31:0]       mem_data;
    logic [7:0]        out_byte;
    logic [7:0]        exp_q[$];
    int                err_count = 0, total_checks = 0;

    wof_formatter wof_formatter_inst (.*);
    wof_host_model wof_host_model_inst (.*);

    always #25 clk_sys = ~clk_sys;

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask : cyc

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        total_checks++;
        if (seen !== want)
        begin
            err_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check

    task automatic report_and_stop;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : report_and_stop

    // sample 1 is a hole location in the model's memory
    task automatic run(input logic [1:0] f, input logic [1:0] s, input logic o, input logic w, input int n);
        logic [31:0] d;
        int nb;
        fmt_value = f;
        fmt_write = 1;
        cyc(1);
        fmt_write = 0;
        check(fmt_current, f);
        src_select = wof_pkg::wof_src_e'(s);
        byte_order_setting = o;
        slow = w;
        src_points = 24'(n);
        exp_q.delete();
        wof_host_model_inst.got.delete();
        for (int i = 0; i < n; i++)
        begin
            d = wof_host_model_inst.sample(24'(i));
            nb = (s == 2'h3 && f == `WOF_FMT_BINARY) ? 4 : (f == `WOF_FMT_BYTE || (f == `WOF_FMT_BINARY && s == 2'h1)) ? 1 : 2;
            if (nb == 1)
                d = (s != 2'h0) ? d[7:0] : (i == 1) ? `WOF_HOLE_BYTE : d[15:8];
            else if (nb == 2)
                d = (s == 2'h0 && i == 1) ? `WOF_HOLE_WORD : d[15:0];
            for (int k = 0; k < nb; k++)
                exp_q.push_back(d[8 * (o ? nb - 1 - k : k) +: 8]);
        end
        cyc(1);
        check(points_answer, n);
        start = 1;
        cyc(1);
        start = 0;
        if (f == `WOF_FMT_BYTE && s == 2'h2)
        begin
            check(fmt_error, 1);
            exp_q.delete();
        end
        for (int t = 0; t < 400 && (busy || out_valid); t++)
            cyc(1);
        // a download that never drains counts as a mismatch here
        check(busy || out_valid, 0);
        check(wof_host_model_inst.got.size(), exp_q.size());
        foreach (exp_q[i])
            check(wof_host_model_inst.got[i], exp_q[i]);
    endtask : run

    initial
    begin
        cyc(3);
        resetn = 1;
        check(fmt_current, `WOF_FMT_TEXT);
        run(`WOF_FMT_WORD, 2'h0, 1, 0, 3);
        run(`WOF_FMT_WORD, 2'h0, 0, 1, 3);
        run(`WOF_FMT_BYTE, 2'h0, 1, 1, 6);
        run(`WOF_FMT_BYTE, 2'h1, 0, 0, 3);
        run(`WOF_FMT_BINARY, 2'h1, 1, 0, 3);
        run(`WOF_FMT_BINARY, 2'h2, 0, 1, 3);
        run(`WOF_FMT_BINARY, 2'h0, 1, 0, 3);
        run(`WOF_FMT_BINARY, 2'h3, 1, 1, 3);
        run(`WOF_FMT_BINARY, 2'h3, 0, 0, 3);
        run(`WOF_FMT_BYTE, 2'h2, 1, 0, 3);
        run(`WOF_FMT_TEXT, 2'h0, 1, 0, 1);
        report_and_stop();
    end

    initial
    begin
        #200000;
        err_count++;
        report_and_stop();
    end
endmodule : testbench
